// ---- src/prsl_consts.vh ----
/*
  Constants for the port split link recovery block: register offsets,
  field positions, reset values, pin routing codes and timing figures.
  Assumes a single 100 MHz hub clock and byte-wide configuration registers.
*/
// Functional notes
// - Split offered only on downstream ports 4, 5
// - Settings loaded by SMBus config or OTP
// - Port power pin keeps governing USB 2.0 half
// - Split activates separate SuperSpeed power GPIO pin
// - No overcurrent sensing on split power pin
// - Port 4 select: 0x42 option A, 0x05 B
// - Port 5 select: 0x06 option A, 0x04 B
// - Enable bit 5 port 4, bit 6 port 5
// - Stuck link while split pulses split power pin
// - Watchdog timer restarts whenever timeout expires
// - Stuck means one state 0x4..0x9 whole timeout
// - Timeout register default 0x05, one second
// - Timeout setting zero disables link watchdog
// - Pin held low for toggle time, default 400 ms
// - High-speed and SuperSpeed halves run independently
// - Timeout field decode, 111 reserved, upper zero
// - Low time 350 ms plus 10 ms per step
`ifndef PRSL_CONSTS_VH
`define PRSL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRSL_ADDR_SPLIT_EN 16'h3C48
`define PRSL_ADDR_P4_SEL 16'h416E
`define PRSL_ADDR_P5_SEL 16'h416F
`define PRSL_ADDR_TIMEOUT 16'h4171
`define PRSL_ADDR_LOW_TIME 16'h4176

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PRSL_EN_BIT_P4 5
`define PRSL_EN_BIT_P5 6
`define PRSL_SPLIT_EN_RST 8'h00
`define PRSL_SEL_RST 8'h00
`define PRSL_TIMEOUT_RST 3'h5
`define PRSL_LOW_TIME_RST 8'h05

// ----------------------------------------
// Pin routing codes
// ----------------------------------------
`define PRSL_P4_SEL_A 8'h42
`define PRSL_P4_SEL_B 8'h05
`define PRSL_P5_SEL_A 8'h06
`define PRSL_P5_SEL_B 8'h04

// ----------------------------------------
// Link states counted as stuck
// ----------------------------------------
`define PRSL_STUCK_LO 4'h4
`define PRSL_STUCK_HI 4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define PRSL_CLK_PERIOD_NS 10
`define PRSL_TICK_NS 1000000
`define PRSL_TICK_CYCLES (`PRSL_TICK_NS / `PRSL_CLK_PERIOD_NS)
`define PRSL_TO_100_MS 12'h064
`define PRSL_TO_250_MS 12'h0FA
`define PRSL_TO_500_MS 12'h1F4
`define PRSL_TO_750_MS 12'h2EE
`define PRSL_TO_1000_MS 12'h3E8
`define PRSL_TO_2000_MS 12'h7D0
`define PRSL_LOW_BASE_MS 12'h15E
`define PRSL_LOW_STEP_MS 4'hA

`endif

// ---- src/prsl_link_watchdog.v ----
/*
  Per-port link watchdog: watches the link state status, and while the
  port is split pulses its SuperSpeed power low when the link is stuck.
  Assumes a one-cycle millisecond tick from the parent and settings
  that are already decoded to milliseconds.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prsl_consts.vh"

module prsl_link_watchdog (
  input wire clk_in,
  input wire nrst_in,
  input wire split_in,
  input wire tick_in,
  input wire [11:0] timeout_ms_in,
  input wire [11:0] low_ms_in,
  input wire [3:0] link_state_in,
  output reg power_on_out,
  output reg pulse_out
);

  localparam ST_WATCH = 1'b0;
  localparam ST_LOW = 1'b1;

  reg state_r;
  reg [11:0] count_r;
  reg [3:0] last_r;
  wire stuck_state;
  wire moved;

  assign stuck_state = (link_state_in >= `PRSL_STUCK_LO) && (link_state_in <= `PRSL_STUCK_HI);
  assign moved = link_state_in != last_r;

  // ----------------------------------------
  // Watch and low-pulse sequencing
  // ----------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_WATCH;
      count_r <= 12'h000;
      last_r <= 4'h0;
      power_on_out <= 1'b1;
      pulse_out <= 1'b0;
    end else begin
      last_r <= link_state_in;
      pulse_out <= 1'b0;
      if (!split_in) begin
        state_r <= ST_WATCH;
        count_r <= 12'h000;
        power_on_out <= 1'b1;
      end else begin
        case (state_r)
          ST_WATCH: begin
            power_on_out <= 1'b1;
            // Any movement or a valid state means the link is alive
            if (timeout_ms_in == 12'h000 || !stuck_state || moved) begin
              count_r <= 12'h000;
            end else if (tick_in) begin
              if (count_r + 12'h001 >= timeout_ms_in) begin
                count_r <= 12'h000;
                state_r <= ST_LOW;
                power_on_out <= 1'b0;
                pulse_out <= 1'b1;
              end else begin
                count_r <= count_r + 12'h001;
              end
            end
          end
          ST_LOW: begin
            power_on_out <= 1'b0;
            if (tick_in) begin
              if (count_r + 12'h001 >= low_ms_in) begin
                count_r <= 12'h000;
                state_r <= ST_WATCH;
                power_on_out <= 1'b1;
              end else begin
                count_r <= count_r + 12'h001;
              end
            end
          end
          default: begin
            state_r <= ST_WATCH;
            count_r <= 12'h000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/prsl_port_split.v ----
/*
  Port split top: configuration registers for splitting downstream ports
  4 and 5, routing of the SuperSpeed split power function onto GPIO pins,
  and one link watchdog per split port.
  Assumes the SMBus slave and the OTP loader present decoded byte writes
  and reads, and that link state and port power requests are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prsl_consts.vh"

module prsl_port_split #(
  parameter TICK_CYCLES = `PRSL_TICK_CYCLES
) (
  input wire clk_in,
  input wire nrst_in,
  // Configuration access
  input wire cfg_stage_in,
  input wire smb_wr_in,
  input wire smb_rd_in,
  input wire [15:0] smb_addr_in,
  input wire [7:0] smb_wdata_in,
  output reg [7:0] smb_rdata_out,
  output reg smb_rvalid_out,
  output reg smb_hit_out,
  input wire otp_wr_in,
  input wire [15:0] otp_addr_in,
  input wire [7:0] otp_data_in,
  // Hub port power requests and link status
  input wire port4_power_req_in,
  input wire port5_power_req_in,
  input wire [3:0] link_state_status4_in,
  input wire [3:0] link_state_status5_in,
  // Power pins
  output reg port4_power_control_pin_out,
  output reg port5_power_control_pin_out,
  output reg port4_ss_power_out,
  output reg port5_ss_power_out,
  output reg gpio66_out,
  output reg gpio66_oe_out,
  output reg gpio6_out,
  output reg gpio6_oe_out,
  output reg gpio5_out,
  output reg gpio5_oe_out,
  output reg gpio4_out,
  output reg gpio4_oe_out,
  output reg [1:0] split_active_out,
  output reg [1:0] link_reset_pulse_out
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [7:1] split_enable_r;
  reg [7:0] port4_split_pin_select_r;
  reg [7:0] port5_split_pin_select_r;
  reg [2:0] link_watchdog_timeout_r;
  reg [7:0] link_reset_low_time_r;

  wire wr_any;
  wire [15:0] wr_addr;
  wire [7:0] wr_data;

  // SMBus writes count only in the configuration stage; OTP loads always
  assign wr_any = (smb_wr_in && cfg_stage_in) || otp_wr_in;
  assign wr_addr = otp_wr_in ? otp_addr_in : smb_addr_in;
  assign wr_data = otp_wr_in ? otp_data_in : smb_wdata_in;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      split_enable_r <= 7'h00;
      port4_split_pin_select_r <= `PRSL_SEL_RST;
      port5_split_pin_select_r <= `PRSL_SEL_RST;
      link_watchdog_timeout_r <= `PRSL_TIMEOUT_RST;
      link_reset_low_time_r <= `PRSL_LOW_TIME_RST;
    end else if (wr_any) begin
      case (wr_addr)
        `PRSL_ADDR_SPLIT_EN: begin
          split_enable_r <= wr_data[7:1];
        end
        `PRSL_ADDR_P4_SEL: begin
          port4_split_pin_select_r <= wr_data;
        end
        `PRSL_ADDR_P5_SEL: begin
          port5_split_pin_select_r <= wr_data;
        end
        `PRSL_ADDR_TIMEOUT: begin
          link_watchdog_timeout_r <= wr_data[2:0];
        end
        `PRSL_ADDR_LOW_TIME: begin
          link_reset_low_time_r <= wr_data;
        end
        default: begin
          split_enable_r <= split_enable_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  reg [7:0] rd_nxt;
  reg hit_nxt;

  always @* begin
    rd_nxt = 8'h00;
    hit_nxt = 1'b1;
    case (smb_addr_in)
      `PRSL_ADDR_SPLIT_EN: begin
        rd_nxt = {split_enable_r, 1'b0};
      end
      `PRSL_ADDR_P4_SEL: begin
        rd_nxt = port4_split_pin_select_r;
      end
      `PRSL_ADDR_P5_SEL: begin
        rd_nxt = port5_split_pin_select_r;
      end
      `PRSL_ADDR_TIMEOUT: begin
        rd_nxt = {5'h00, link_watchdog_timeout_r};
      end
      `PRSL_ADDR_LOW_TIME: begin
        rd_nxt = link_reset_low_time_r;
      end
      default: begin
        hit_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      smb_rdata_out <= 8'h00;
      smb_rvalid_out <= 1'b0;
      smb_hit_out <= 1'b0;
    end else begin
      smb_rvalid_out <= smb_rd_in;
      if (smb_rd_in) begin
        smb_rdata_out <= rd_nxt;
        smb_hit_out <= hit_nxt;
      end
    end
  end

  // ----------------------------------------
  // Decoded settings
  // ----------------------------------------
  reg [11:0] timeout_ms;
  wire [11:0] low_ms;

  always @* begin
    case (link_watchdog_timeout_r)
      3'h1: timeout_ms = `PRSL_TO_100_MS;
      3'h2: timeout_ms = `PRSL_TO_250_MS;
      3'h3: timeout_ms = `PRSL_TO_500_MS;
      3'h4: timeout_ms = `PRSL_TO_750_MS;
      3'h5: timeout_ms = `PRSL_TO_1000_MS;
      3'h6: timeout_ms = `PRSL_TO_2000_MS;
      // Reserved code treated like never, the safe reading
      default: timeout_ms = 12'h000;
    endcase
  end

  assign low_ms = `PRSL_LOW_BASE_MS + ({4'h0, link_reset_low_time_r} * {8'h00, `PRSL_LOW_STEP_MS});

  // Only bits 5 and 6 enable anything; bits 1-4 and 7 are storage only, bit 0 is not kept
  wire [1:0] split_en;
  assign split_en = {split_enable_r[`PRSL_EN_BIT_P5], split_enable_r[`PRSL_EN_BIT_P4]};

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  reg [31:0] tick_cnt_r;
  reg tick_r;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Per-port watchdogs
  // ----------------------------------------
  wire [7:0] link_states;
  wire [1:0] wd_power_on;
  wire [1:0] wd_pulse;

  assign link_states = {link_state_status5_in, link_state_status4_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      prsl_link_watchdog u_wd (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .split_in(split_en[gi]),
        .tick_in(tick_r),
        .timeout_ms_in(timeout_ms),
        .low_ms_in(low_ms),
        .link_state_in(link_states[gi*4 +: 4]),
        .power_on_out(wd_power_on[gi]),
        .pulse_out(wd_pulse[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  wire p4_a;
  wire p4_b;
  wire p5_a;
  wire p5_b;
  wire ss4;
  wire ss5;

  assign p4_a = split_en[0] && (port4_split_pin_select_r == `PRSL_P4_SEL_A);
  assign p4_b = split_en[0] && (port4_split_pin_select_r == `PRSL_P4_SEL_B);
  assign p5_a = split_en[1] && (port5_split_pin_select_r == `PRSL_P5_SEL_A);
  assign p5_b = split_en[1] && (port5_split_pin_select_r == `PRSL_P5_SEL_B);
  // Split pin is drive only; no sense path exists on it
  assign ss4 = port4_power_req_in && wd_power_on[0];
  assign ss5 = port5_power_req_in && wd_power_on[1];

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port4_power_control_pin_out <= 1'b0;
      port5_power_control_pin_out <= 1'b0;
      port4_ss_power_out <= 1'b0;
      port5_ss_power_out <= 1'b0;
      gpio66_out <= 1'b0;
      gpio66_oe_out <= 1'b0;
      gpio6_out <= 1'b0;
      gpio6_oe_out <= 1'b0;
      gpio5_out <= 1'b0;
      gpio5_oe_out <= 1'b0;
      gpio4_out <= 1'b0;
      gpio4_oe_out <= 1'b0;
      split_active_out <= 2'h0;
      link_reset_pulse_out <= 2'h0;
    end else begin
      port4_power_control_pin_out <= port4_power_req_in;
      port5_power_control_pin_out <= port5_power_req_in;
      // Unsplit ports keep the SuperSpeed half on the shared power
      port4_ss_power_out <= split_en[0] ? ss4 : port4_power_req_in;
      port5_ss_power_out <= split_en[1] ? ss5 : port5_power_req_in;
      gpio66_out <= p4_a && ss4;
      gpio66_oe_out <= p4_a;
      gpio5_out <= p4_b && ss4;
      gpio5_oe_out <= p4_b;
      gpio6_out <= p5_a && ss5;
      gpio6_oe_out <= p5_a;
      gpio4_out <= p5_b && ss5;
      gpio4_oe_out <= p5_b;
      split_active_out <= split_en;
      link_reset_pulse_out <= wd_pulse;
    end
  end

endmodule
`default_nettype wire

// ---- sim/prsl_port_split_chk.sv ----
/* Checker for the port split top, seen only at its pins.
   Assumes bind onto prsl_port_split and the same TICK_CYCLES. */
`timescale 1ns/1ps
`default_nettype none
module prsl_port_split_chk #(
  parameter TICK_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic smb_rd_in,
  input wire logic smb_rvalid_out,
  input wire logic port4_power_req_in,
  input wire logic port5_power_req_in,
  input wire logic [3:0] link_state_status4_in,
  input wire logic port4_power_control_pin_out,
  input wire logic port5_power_control_pin_out,
  input wire logic port4_ss_power_out,
  input wire logic gpio66_out,
  input wire logic gpio66_oe_out,
  input wire logic gpio5_oe_out,
  input wire logic gpio6_oe_out,
  input wire logic gpio4_oe_out,
  input wire logic [1:0] split_active_out,
  input wire logic [1:0] link_reset_pulse_out
);
  // ----
  // Low time since a port 4 reset pulse
  // ----
  localparam int LO_MIN = 350 * TICK_CYCLES - 8;
  reg [15:0] lo_cnt_r;
  reg in_lo_r;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lo_cnt_r <= 16'h0000;
      in_lo_r <= 1'b0;
    end else if (link_reset_pulse_out[0]) begin
      lo_cnt_r <= 16'h0000;
      in_lo_r <= 1'b1;
    end else if (port4_ss_power_out) begin
      in_lo_r <= 1'b0;
    end else begin
      lo_cnt_r <= lo_cnt_r + 16'h0001;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  usb2_pin_four_a: assert property (
    $past(nrst_in) |-> port4_power_control_pin_out == $past(port4_power_req_in))
    else $error("port 4 usb2 pin not following request");
  usb2_pin_five_a: assert property (
    $past(nrst_in) |-> port5_power_control_pin_out == $past(port5_power_req_in))
    else $error("port 5 usb2 pin not following request");
  ss_power_gate_a: assert property (
    !port4_power_req_in [*2] |=> !port4_ss_power_out)
    else $error("superspeed power on without request");
  pin_mirror_a: assert property (
    gpio66_oe_out |-> gpio66_out == port4_ss_power_out)
    else $error("routed pin differs from superspeed power");
  four_pin_mux_a: assert property (
    !(gpio66_oe_out && gpio5_oe_out)) else $error("port 4 split on two pins");
  five_pin_mux_a: assert property (
    !(gpio6_oe_out && gpio4_oe_out)) else $error("port 5 split on two pins");
  pulse_split_a: assert property (
    link_reset_pulse_out[0] |-> split_active_out[0]) else $error("pulse on unsplit port");
  pulse_stuck_a: assert property (
    link_reset_pulse_out[0] |-> $past(link_state_status4_in) inside {[4'h4:4'h9]})
    else $error("pulse while link not stuck");
  pulse_single_a: assert property (
    link_reset_pulse_out[0] |=> !link_reset_pulse_out[0]) else $error("pulse longer than one cycle");
  pulse_drop_a: assert property (
    link_reset_pulse_out[0] |-> ##[0:3] !port4_ss_power_out) else $error("power not cut after pulse");
  low_time_a: assert property (
    $rose(port4_ss_power_out) && in_lo_r && split_active_out[0] |-> lo_cnt_r >= LO_MIN)
    else $error("superspeed power restored too early");
  read_answer_a: assert property (
    $past(nrst_in) |-> smb_rvalid_out == $past(smb_rd_in)) else $error("read answer misplaced");
  cover property (link_reset_pulse_out[0]);
  cover property (link_reset_pulse_out[1]);
  cover property (smb_rvalid_out && split_active_out == 2'b11);
endmodule
bind prsl_port_split prsl_port_split_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.clk_in, .nrst_in,
  .smb_rd_in, .smb_rvalid_out, .port4_power_req_in, .port5_power_req_in, .link_state_status4_in,
  .port4_power_control_pin_out, .port5_power_control_pin_out, .port4_ss_power_out, .gpio66_out,
  .gpio66_oe_out, .gpio5_oe_out, .gpio6_oe_out, .gpio4_oe_out, .split_active_out, .link_reset_pulse_out);
`default_nettype wire

// ---- sim/prsl_link_partner.sv ----
/* Embedded SuperSpeed device behind a split power pin.
   Assumes the bench feeds it the resolved pin level. */
`timescale 1ns/1ps
`default_nettype none
module prsl_link_partner (
  input wire logic clk_in,
  input wire logic power_in,
  input wire logic fresh_in,
  input wire logic [3:0] need_in,
  output logic [3:0] link_state_out
);
  // Soldered down, so no hot-plug is modelled
  int drops = 0;
  int up_cnt = 0;
  logic pw_d = 1'b0;
  always @(posedge clk_in) begin
    pw_d <= power_in;
    up_cnt <= power_in ? up_cnt + 1 : 0;
    if (fresh_in) drops <= 0;
    else if (pw_d && !power_in) drops <= drops + 1;
  end
  // Slow start: polling first, link only after enough power cycles
  always @* begin
    if (!power_in) link_state_out = 4'h5;
    else if (up_cnt < 20) link_state_out = 4'h7;
    else if (drops >= need_in) link_state_out = 4'h0;
    else link_state_out = 4'h5;
  end
endmodule
`default_nettype wire

// ---- sim/prsl_port_split_tb_top.sv ----
/* Bench for the port split block: registers, pin routing, watchdog.
   Assumes TICK_CYCLES of 4, so one millisecond is four clocks. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (e)); \
  end \
end
module prsl_port_split_tb_top;
  localparam int TICK = 4;
  logic clk_in = 1'b0, nrst_in = 1'b0, cfg_stage_in = 1'b0, smb_wr_in = 1'b0, smb_rd_in = 1'b0;
  logic [15:0] smb_addr_in = 16'h0000, otp_addr_in = 16'h0000;
  logic [7:0] smb_wdata_in = 8'h00, otp_data_in = 8'h00, smb_rdata_out;
  logic otp_wr_in = 1'b0, port4_power_req_in = 1'b0, port5_power_req_in = 1'b0, fresh = 1'b0;
  logic [3:0] need4 = 4'h0, need5 = 4'h0, link_state_status4_in, link_state_status5_in;
  logic smb_rvalid_out, smb_hit_out, port4_power_control_pin_out, port5_power_control_pin_out;
  logic port4_ss_power_out, port5_ss_power_out, gpio66_out, gpio66_oe_out, gpio6_out, gpio6_oe_out;
  logic gpio5_out, gpio5_oe_out, gpio4_out, gpio4_oe_out;
  logic [1:0] split_active_out, link_reset_pulse_out;
  logic [8:0] exp_q[$];
  logic [8:0] got;
  logic [15:0] adr_v [5] = '{16'h3C48, 16'h416E, 16'h416F, 16'h4171, 16'h4176};
  logic [7:0] rst_v [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h05};
  logic [7:0] sel_v [4] = '{8'h42, 8'h05, 8'h06, 8'h04};
  logic [3:0] oe_v [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  int ms_v [7] = '{0, 100, 250, 500, 750, 1000, 2000};
  int err_count = 0, total_checks = 0, pc4 = 0, pc5 = 0, i, k, k5, n;
  int unsigned xs_r = 78, r;
  // Undriven split pins are pulled down, so the device is off
  wire pin4 = gpio66_oe_out ? gpio66_out : 1'b0;
  wire pin5 = gpio6_oe_out ? gpio6_out : 1'b0;
  prsl_port_split #(.TICK_CYCLES(TICK)) uut (.clk_in, .nrst_in, .cfg_stage_in, .smb_wr_in, .smb_rd_in,
    .smb_addr_in, .smb_wdata_in, .smb_rdata_out, .smb_rvalid_out, .smb_hit_out, .otp_wr_in, .otp_addr_in,
    .otp_data_in, .port4_power_req_in, .port5_power_req_in, .link_state_status4_in, .link_state_status5_in,
    .port4_power_control_pin_out, .port5_power_control_pin_out, .port4_ss_power_out, .port5_ss_power_out,
    .gpio66_out, .gpio66_oe_out, .gpio6_out, .gpio6_oe_out, .gpio5_out, .gpio5_oe_out, .gpio4_out,
    .gpio4_oe_out, .split_active_out, .link_reset_pulse_out);
  prsl_link_partner dev4 (.clk_in, .power_in(pin4), .fresh_in(fresh), .need_in(need4),
    .link_state_out(link_state_status4_in));
  prsl_link_partner dev5 (.clk_in, .power_in(pin5), .fresh_in(fresh), .need_in(need5),
    .link_state_out(link_state_status5_in));
  always #5 clk_in = ~clk_in;
  // ----
  // Bus tasks and closing
  // ----
  function automatic int unsigned xs();
    xs_r ^= xs_r << 13;
    xs_r ^= xs_r >> 17;
    xs_r ^= xs_r << 5;
    return xs_r;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic c);
    @(negedge clk_in);
    cfg_stage_in = c;
    smb_addr_in = a;
    smb_wdata_in = d;
    smb_wr_in = 1'b1;
    @(negedge clk_in);
    smb_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [8:0] e);
    @(negedge clk_in);
    exp_q.push_back(e);
    smb_addr_in = a;
    smb_rd_in = 1'b1;
    @(negedge clk_in);
    smb_rd_in = 1'b0;
  endtask
  task automatic otp(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    otp_addr_in = a;
    otp_data_in = d;
    otp_wr_in = 1'b1;
    @(negedge clk_in);
    otp_wr_in = 1'b0;
  endtask
  task automatic wait_p4(output int m);
    int k0;
    k0 = pc4;
    m = 0;
    while (pc4 == k0 && m < 9000) begin
      @(negedge clk_in);
      m++;
    end
    if (m >= 9000) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Result watchers
  // ----
  always @(posedge clk_in) begin
    if (link_reset_pulse_out[0] === 1'b1) pc4++;
    if (link_reset_pulse_out[1] === 1'b1) pc5++;
  end
  always @(negedge clk_in) begin
    if (smb_rvalid_out === 1'b1) begin
      got = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF;
      `CHK({smb_hit_out, smb_rdata_out}, got)
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    for (i = 0; i < 5; i++) rd(adr_v[i], {1'b1, rst_v[i]});
    rd(16'h1234, 9'h000);
    wr(16'h3C48, 8'h60, 1'b0);
    rd(16'h3C48, 9'h100);
    wr(16'h3C48, 8'hFF, 1'b1);
    rd(16'h3C48, 9'h1FE);
    wr(16'h4171, 8'hFF, 1'b1);
    rd(16'h4171, 9'h107);
    otp(16'h4171, 8'h03);
    rd(16'h4171, 9'h103);
    for (i = 0; i < 6; i++) begin
      r = xs();
      port4_power_req_in = r[0];
      port5_power_req_in = r[1];
      wr(16'h4176, r[15:8], 1'b1);
      rd(16'h4176, {1'b1, r[15:8]});
    end
    port4_power_req_in = 1'b1;
    port5_power_req_in = 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(i < 2 ? 16'h416E : 16'h416F, sel_v[i], 1'b1);
      wr(16'h3C48, i < 2 ? 8'h20 : 8'h40, 1'b1);
      repeat (3) @(negedge clk_in);
      `CHK({gpio66_oe_out, gpio5_oe_out, gpio6_oe_out, gpio4_oe_out}, oe_v[i])
      `CHK({gpio66_out, gpio5_out, gpio6_out, gpio4_out}, oe_v[i])
      `CHK(split_active_out, i < 2 ? 2'b01 : 2'b10)
    end
    need4 = 4'hF;
    wr(16'h416E, 8'h42, 1'b1);
    wr(16'h3C48, 8'h20, 1'b1);
    for (i = 0; i < 2; i++) begin
      wr(16'h4171, i ? 8'h07 : 8'h00, 1'b1);
      k = pc4;
      repeat (3000) @(negedge clk_in);
      `CHK(pc4 - k, 0)
    end
    for (i = 1; i < 7; i++) begin
      wr(16'h3C48, 8'h00, 1'b1);
      wr(16'h4171, i[7:0], 1'b1);
      wr(16'h3C48, 8'h20, 1'b1);
      wait_p4(n);
      // Partner polls about 20 cycles after power-up before it stalls
      `CHK(n >= ms_v[i] * TICK + 14 && n <= ms_v[i] * TICK + 30, 1'b1)
    end
    wr(16'h3C48, 8'h00, 1'b1);
    wr(16'h4176, 8'h00, 1'b1);
    wr(16'h416F, 8'h06, 1'b1);
    need4 = 4'h1;
    need5 = 4'h2;
    fresh = 1'b1;
    @(negedge clk_in);
    fresh = 1'b0;
    k = pc4;
    k5 = pc5;
    wr(16'h4171, 8'h01, 1'b1);
    wr(16'h3C48, 8'h60, 1'b1);
    wait_p4(n);
    n = 0;
    while (port4_ss_power_out !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      tally_and_finish();
    end
    `CHK(n >= 350 * TICK - 8 && n <= 350 * TICK + 8, 1'b1)
    repeat (4000) @(negedge clk_in);
    `CHK(pc4 - k, 1)
    `CHK(pc5 - k5, 2)
    `CHK({port4_ss_power_out, pin4}, 2'b11)
    `CHK({port5_ss_power_out, pin5}, 2'b11)
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
